// ### ccm_block_map.sv
// package of shared constants and the per-kind block address matcher
package ccm_pkg;
  localparam int ADDR_W = 20;                 // target address width
  localparam int NBLK = 8;                    // blocks per store
  localparam int BLK_W = 3;                   // block number width
  localparam int STMT_SHIFT = 18;             // 256-kbyte block alignment
  localparam int BR_SHIFT = 17;               // 128-kbyte block alignment
  localparam int STMT_IDX_W = BLK_W + STMT_SHIFT; // 2M statement entries
  localparam int BR_IDX_W = BLK_W + BR_SHIFT; // 1M branch entries
  localparam int STMT_ENTRIES = 1 << STMT_IDX_W;
  localparam int BR_ENTRIES = 1 << BR_IDX_W;
  localparam int RET_ENTRIES = 1 << ADDR_W;   // one retention entry per address
  localparam int SWEEP_W = STMT_IDX_W;        // sweep counter width
  localparam logic [ADDR_W-1:0] STMT_ROM_BASE = 20'hc0000; // default rom block
  localparam logic [ADDR_W-1:0] STMT_RAM_BASE = 20'h00000; // default ram block
  localparam logic [ADDR_W-1:0] BR_ROM_BASE = 20'he0000;   // default rom block
  localparam logic [ADDR_W-1:0] BR_RAM_BASE = 20'h00000;   // default ram block
  localparam logic [NBLK-1:0] DEF_EN = 8'h03;  // blocks 0 and 1 enabled
  localparam logic KIND_STMT = 1'b0;          // config kind codes
  localparam logic KIND_BR = 1'b1;
  typedef enum logic [1:0] {ST_CLEAR, ST_IDLE, ST_REMAP} ccm_state_t;
endpackage : ccm_pkg

module ccm_block_map #(
  parameter int SHIFT = 18,
  parameter logic [ccm_pkg::ADDR_W-1:0] DEF_B0 = '0,
  parameter logic [ccm_pkg::ADDR_W-1:0] DEF_B1 = '0
) (
  input wire logic clk_i,                                  // system clock
  input wire logic rst_n_i,                                // synced reset, low
  input wire logic wr_i,                                   // commit block entry
  input wire logic [ccm_pkg::BLK_W-1:0] wr_blk_i,          // block to write
  input wire logic wr_en_i,                                // block enabled
  input wire logic [ccm_pkg::ADDR_W-1:0] wr_base_i,        // base, low bits dropped
  input wire logic [ccm_pkg::ADDR_W-1:0] look_addr_i,      // address to match
  output logic hit_o,                                      // address mapped
  output logic [ccm_pkg::BLK_W+SHIFT-1:0] idx_o,           // store entry index
  input wire logic [ccm_pkg::BLK_W-1:0] sel_blk_i,         // block to describe
  output logic sel_en_o,                                   // that block enabled
  output logic [ccm_pkg::ADDR_W-1:0] sel_base_o            // that block base
);
  import ccm_pkg::*;
  localparam int HI_W = ADDR_W - SHIFT;     // width of an aligned base

  logic [HI_W-1:0] base_reg [NBLK];         // aligned block bases
  logic [NBLK-1:0] en_reg;                  // block enables

  // map table; default puts rom first then ram
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NBLK; i++) begin
        base_reg[i] <= '0;
      end
      base_reg[0] <= DEF_B0[ADDR_W-1:SHIFT];  // [R7]
      base_reg[1] <= DEF_B1[ADDR_W-1:SHIFT];  // [R7]
      en_reg <= DEF_EN;
    end else if (wr_i) begin
      // alignment forced by dropping the low bits [R9] [R10]
      base_reg[wr_blk_i] <= wr_base_i[ADDR_W-1:SHIFT];
      en_reg[wr_blk_i] <= wr_en_i;
    end
  end

  // compare against every block; any order of bases allowed [R11] [R15]
  always_comb begin
    hit_o = 1'b0;
    idx_o = '0;
    // walk downward so the lowest numbered block wins a duplicate
    for (int i = NBLK - 1; i >= 0; i--) begin
      if (en_reg[i] && (look_addr_i[ADDR_W-1:SHIFT] == base_reg[i])) begin
        hit_o = 1'b1;
        idx_o = {BLK_W'(i), look_addr_i[SHIFT-1:0]};  // [R15]
      end
    end
  end

  // base of a chosen block, for turning an index back into an address
  assign sel_en_o = en_reg[sel_blk_i];
  assign sel_base_o = {base_reg[sel_blk_i], {SHIFT{1'b0}}};
endmodule : ccm_block_map

// ### ccm_top.sv
// coverage capture core: statement and branch stores with retention buffer
//
// Notes on behaviour
// R1 - observe target passively, never stall it
// R2 - results readable only while target is halted
// R3 - mark executed address in statement store
// R4 - mark each exercised branch in branch store
// R5 - combined mode covers at most two megabytes
// R6 - branch-only mode covers at most one megabyte
// R7 - default map: rom block, then ram
// R8 - unmapped addresses leave coverage untouched
// R9 - statement blocks: 1-8, 256k aligned
// R10 - branch blocks: 1-8, 128k aligned
// R11 - blocks may be adjacent or scattered
// R12 - remap moves old data to retention
// R13 - record branch true and false separately
// R14 - coverage accumulates until host clear
// R15 - match address to block, offset selects entry
module ccm_top #(
  parameter logic [ccm_pkg::SWEEP_W-1:0] SWEEP_LAST = ccm_pkg::SWEEP_W'(ccm_pkg::STMT_ENTRIES - 1)
) (
  input wire logic clk_i,                             // 100 mhz clock
  input wire logic resetn_i,                          // async reset, low
  input wire logic halted_i,                          // target stopped at break
  input wire logic mode_both_i,                       // 1 stmt+branch, 0 branch only
  input wire logic fetch_valid_i,                     // instruction executed
  input wire logic [ccm_pkg::ADDR_W-1:0] fetch_addr_i, // its address
  input wire logic br_valid_i,                        // conditional branch resolved
  input wire logic [ccm_pkg::ADDR_W-1:0] br_addr_i,   // branch address
  input wire logic br_taken_i,                        // condition true
  input wire logic clear_i,                           // host clear pulse
  input wire logic cfg_we_i,                          // host map write pulse
  input wire logic cfg_kind_i,                        // 0 stmt map, 1 branch map
  input wire logic [ccm_pkg::BLK_W-1:0] cfg_blk_i,    // block number
  input wire logic cfg_en_i,                          // block enable
  input wire logic [ccm_pkg::ADDR_W-1:0] cfg_base_i,  // block base address
  input wire logic rd_en_i,                           // readout request
  input wire logic [ccm_pkg::ADDR_W-1:0] rd_addr_i,   // readout address
  output logic busy_o,                                // clear or remap sweep
  output logic rd_valid_o,                            // readout answer
  output logic rd_exec_o,                             // address executed
  output logic rd_true_o,                             // branch seen true
  output logic rd_false_o,                            // branch seen false
  output logic rd_mapped_o                            // address has a live block
);
  import ccm_pkg::*;

  logic [1:0] rst_sync_reg;                  // reset release pipeline
  logic rst_n;                               // synced reset
  ccm_state_t state_reg;                     // sweep controller state
  logic [SWEEP_W-1:0] sweep_reg;             // sweep index
  logic pend_kind_reg;                       // pending map write kind
  logic [BLK_W-1:0] pend_blk_reg;            // pending block
  logic pend_en_reg;                         // pending enable
  logic [ADDR_W-1:0] pend_base_reg;          // pending base
  logic stmt_mem [STMT_ENTRIES];             // statement executed bits
  logic br_t_mem [BR_ENTRIES];               // branch seen true
  logic br_f_mem [BR_ENTRIES];               // branch seen false
  logic ret_exec_mem [RET_ENTRIES];          // retention: executed
  logic ret_t_mem [RET_ENTRIES];             // retention: true
  logic ret_f_mem [RET_ENTRIES];             // retention: false
  logic idle;                                // no sweep running
  logic cfg_take;                            // map write accepted
  logic clr_take;                            // clear accepted
  logic sweep_done;                          // last sweep index
  logic commit;                              // map write lands
  logic [ADDR_W-1:0] s_look;                 // statement lookup address
  logic [ADDR_W-1:0] b_look;                 // branch lookup address
  logic s_hit;                               // statement hit
  logic b_hit;                               // branch hit
  logic [STMT_IDX_W-1:0] s_idx;              // statement entry
  logic [BR_IDX_W-1:0] b_idx;                // branch entry
  logic s_sel_en;                            // swept stmt block enabled
  logic b_sel_en;                            // swept branch block enabled
  logic [ADDR_W-1:0] s_sel_base;             // swept stmt block base
  logic [ADDR_W-1:0] b_sel_base;             // swept branch block base
  logic stmt_wr;                             // statement record strobe
  logic br_wr;                               // branch record strobe
  logic [BR_IDX_W-1:0] sweep_br;             // sweep index in branch store
  logic [ADDR_W-1:0] sweep_ret;              // sweep index in retention
  logic s_move;                              // remap moves this stmt entry
  logic b_move;                              // remap moves this branch entry
  logic [ADDR_W-1:0] s_move_addr;            // target address of stmt entry
  logic [ADDR_W-1:0] b_move_addr;            // target address of branch entry

  // two-flop reset release; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign idle = (state_reg == ST_IDLE);
  // host actions only while halted, so no target event is lost to a sweep
  assign cfg_take = idle && halted_i && cfg_we_i;
  assign clr_take = idle && halted_i && clear_i && !cfg_we_i;
  assign sweep_done = (sweep_reg == SWEEP_LAST);
  assign commit = (state_reg == ST_REMAP) && sweep_done;
  assign sweep_br = sweep_reg[BR_IDX_W-1:0];
  assign sweep_ret = sweep_reg[ADDR_W-1:0];

  // readout address steers lookups while halted, target bus while running
  assign s_look = halted_i ? rd_addr_i : fetch_addr_i;
  assign b_look = halted_i ? rd_addr_i : br_addr_i;

  ccm_block_map #(.SHIFT(STMT_SHIFT), .DEF_B0(STMT_ROM_BASE), .DEF_B1(STMT_RAM_BASE)) u_stmt_map (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .wr_i(commit && (pend_kind_reg == KIND_STMT)),
    .wr_blk_i(pend_blk_reg),
    .wr_en_i(pend_en_reg),
    .wr_base_i(pend_base_reg),
    .look_addr_i(s_look),
    .hit_o(s_hit),
    .idx_o(s_idx),
    .sel_blk_i(sweep_reg[STMT_IDX_W-1:STMT_SHIFT]),
    .sel_en_o(s_sel_en),
    .sel_base_o(s_sel_base)
  );

  ccm_block_map #(.SHIFT(BR_SHIFT), .DEF_B0(BR_ROM_BASE), .DEF_B1(BR_RAM_BASE)) u_br_map (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .wr_i(commit && (pend_kind_reg == KIND_BR)),
    .wr_blk_i(pend_blk_reg),
    .wr_en_i(pend_en_reg),
    .wr_base_i(pend_base_reg),
    .look_addr_i(b_look),
    .hit_o(b_hit),
    .idx_o(b_idx),
    .sel_blk_i(sweep_reg[BR_IDX_W-1:BR_SHIFT]),
    .sel_en_o(b_sel_en),
    .sel_base_o(b_sel_base)
  );

  // record strobes: only while running, only on a mapped hit [R1] [R8]
  // statement store is off in branch-only mode, halving the reach [R5] [R6]
  assign stmt_wr = idle && !halted_i && mode_both_i && fetch_valid_i && s_hit; // [R3]
  assign br_wr = idle && !halted_i && br_valid_i && b_hit;                   // [R4]

  // remap moves only entries of the block being rewritten, of its kind
  assign s_move = (pend_kind_reg == KIND_STMT) && s_sel_en
    && (sweep_reg[STMT_IDX_W-1:STMT_SHIFT] == pend_blk_reg);
  assign b_move = (pend_kind_reg == KIND_BR) && b_sel_en && !sweep_reg[SWEEP_W-1]
    && (sweep_reg[BR_IDX_W-1:BR_SHIFT] == pend_blk_reg);
  assign s_move_addr = s_sel_base | {{(ADDR_W-STMT_SHIFT){1'b0}}, sweep_reg[STMT_SHIFT-1:0]};
  assign b_move_addr = b_sel_base | {{(ADDR_W-BR_SHIFT){1'b0}}, sweep_reg[BR_SHIFT-1:0]};

  // sweep controller: clear after reset, host clear, remap
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CLEAR;               // stores hold junk after power-up
      sweep_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sweep_reg <= '0;
          if (cfg_take) begin
            state_reg <= ST_REMAP;         // [R12]
          end else if (clr_take) begin
            state_reg <= ST_CLEAR;         // [R14]
          end
        end
        ST_CLEAR, ST_REMAP: begin
          sweep_reg <= sweep_reg + SWEEP_W'(1);
          if (sweep_done) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // pending map write, held through the remap sweep
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_kind_reg <= KIND_STMT;
      pend_blk_reg <= '0;
      pend_en_reg <= 1'b0;
      pend_base_reg <= '0;
    end else if (cfg_take) begin
      pend_kind_reg <= cfg_kind_i;
      pend_blk_reg <= cfg_blk_i;
      pend_en_reg <= cfg_en_i;
      pend_base_reg <= cfg_base_i;
    end
  end

  // statement store: sticky set, emptied by clear or moved by remap
  always_ff @(posedge clk_i) begin
    if (state_reg == ST_CLEAR) begin
      stmt_mem[sweep_reg] <= 1'b0;
    end else if ((state_reg == ST_REMAP) && s_move) begin
      stmt_mem[sweep_reg] <= 1'b0;         // [R12]
    end else if (stmt_wr) begin
      stmt_mem[s_idx] <= 1'b1;             // [R3] [R14]
    end
  end

  // branch stores: true and false outcomes kept apart
  always_ff @(posedge clk_i) begin
    if ((state_reg == ST_CLEAR) && !sweep_reg[SWEEP_W-1]) begin
      br_t_mem[sweep_br] <= 1'b0;
      br_f_mem[sweep_br] <= 1'b0;
    end else if ((state_reg == ST_REMAP) && b_move) begin
      br_t_mem[sweep_br] <= 1'b0;          // [R12]
      br_f_mem[sweep_br] <= 1'b0;
    end else if (br_wr) begin
      if (br_taken_i) begin
        br_t_mem[b_idx] <= 1'b1;           // [R13]
      end else begin
        br_f_mem[b_idx] <= 1'b1;           // [R13]
      end
    end
  end

  // retention buffer, indexed by target address; only a clear empties it
  always_ff @(posedge clk_i) begin
    if ((state_reg == ST_CLEAR) && !sweep_reg[SWEEP_W-1]) begin
      ret_exec_mem[sweep_ret] <= 1'b0;
      ret_t_mem[sweep_ret] <= 1'b0;
      ret_f_mem[sweep_ret] <= 1'b0;
    end else if (state_reg == ST_REMAP) begin
      // merge, never overwrite: older runs stay visible [R12] [R14]
      if (s_move && stmt_mem[sweep_reg]) begin
        ret_exec_mem[s_move_addr] <= 1'b1;
      end
      if (b_move && br_t_mem[sweep_br]) begin
        ret_t_mem[b_move_addr] <= 1'b1;
      end
      if (b_move && br_f_mem[sweep_br]) begin
        ret_f_mem[b_move_addr] <= 1'b1;
      end
    end
  end

  // readout only at a break; live store merged with retention [R2]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_o <= 1'b0;
      rd_exec_o <= 1'b0;
      rd_true_o <= 1'b0;
      rd_false_o <= 1'b0;
      rd_mapped_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i && halted_i && idle;  // [R2]
      if (rd_en_i && halted_i && idle) begin
        rd_exec_o <= (s_hit && stmt_mem[s_idx]) || ret_exec_mem[rd_addr_i];
        rd_true_o <= (b_hit && br_t_mem[b_idx]) || ret_t_mem[rd_addr_i];
        rd_false_o <= (b_hit && br_f_mem[b_idx]) || ret_f_mem[rd_addr_i];
        rd_mapped_o <= mode_both_i ? (s_hit || b_hit) : b_hit;
      end
    end
  end

  // busy flag straight from a flop
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b1;
    end else begin
      busy_o <= !((state_reg != ST_IDLE) && sweep_done) && !(idle && !cfg_take && !clr_take);
    end
  end

  sequence seq_cfg_req;
    idle && halted_i && cfg_we_i;
  endsequence
  sequence seq_remap_run;
    (state_reg == ST_REMAP) && busy_o;
  endsequence

  AST_REMAP_START: assert property (@(posedge clk_i) disable iff (!rst_n) // [R12]
    seq_cfg_req |=> seq_remap_run)
    else $error("map write did not start a remap sweep");
  AST_NO_RECORD_HALTED: assert property (@(posedge clk_i) disable iff (!rst_n) // [R1]
    (halted_i && idle && !stmt_mem[s_idx]) |=> !stmt_mem[$past(s_idx)])
    else $error("coverage recorded while halted");
  AST_UNMAPPED_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
    (fetch_valid_i && !halted_i && !s_hit) |-> !stmt_wr)
    else $error("unmapped fetch recorded");
  AST_RD_ONLY_HALTED: assert property (@(posedge clk_i) disable iff (!rst_n) // [R2]
    rd_valid_o |-> $past(halted_i) && $past(rd_en_i))
    else $error("readout answered while running");
  AST_STMT_SET: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
    stmt_wr |=> stmt_mem[$past(s_idx)])
    else $error("executed bit not set");
  AST_BR_TRUE: assert property (@(posedge clk_i) disable iff (!rst_n) // [R13]
    (br_wr && br_taken_i) |=> br_t_mem[$past(b_idx)])
    else $error("branch true not recorded");
  AST_BR_FALSE: assert property (@(posedge clk_i) disable iff (!rst_n) // [R4]
    (br_wr && !br_taken_i) |=> br_f_mem[$past(b_idx)])
    else $error("branch false not recorded");
  AST_BR_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n) // [R6]
    (!mode_both_i && idle && !halted_i && fetch_valid_i && s_hit && !stmt_mem[s_idx]) |=> !stmt_mem[$past(s_idx)])
    else $error("statement recorded in branch-only mode");
  AST_CLEAR_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n) // [R14]
    (idle && halted_i && clear_i && !cfg_we_i) |=> (state_reg == ST_CLEAR) ##1 busy_o)
    else $error("clear did not start a sweep");
endmodule : ccm_top

// ### ccm_core_model.sv
// target core model: free-running fetch and branch events with expected bits
module ccm_core_model (
  input wire logic clk_i,                         // system clock
  output logic fetch_valid_o,                     // instruction executed
  output logic [ccm_pkg::ADDR_W-1:0] fetch_addr_o, // its address
  output logic br_valid_o,                        // branch resolved
  output logic [ccm_pkg::ADDR_W-1:0] br_addr_o,   // branch address
  output logic br_taken_o                         // condition true
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccm_pkg::*;
  logic [255:0] m_exec;  // expected executed bits, low 256 addresses
  logic [255:0] m_true;  // expected branch-true bits
  logic [255:0] m_false; // expected branch-false bits
  logic [31:0] seed;     // xorshift state
  // quiet core at time zero
  initial begin
    seed = 32'h6eaeef88;
    m_exec = '0;
    m_true = '0;
    m_false = '0;
    fetch_valid_o = 1'b0;
    fetch_addr_o = '0;
    br_valid_o = 1'b0;
    br_addr_o = '0;
    br_taken_o = 1'b0;
  end
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // one event pair per cycle; the core never waits on coverage logic
  task automatic run(input int n, input logic [7:0] lo, input logic both);
    logic [7:0] off;
    logic [7:0] boff;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      seed = xs(seed);
      off = lo + {2'b00, seed[13:8]};
      boff = lo + {2'b00, seed[21:16]};
      fetch_valid_o <= seed[0];
      br_valid_o <= seed[1];
      br_taken_o <= seed[2];
      // seed bits 3 and 4 send events to an unmapped area
      fetch_addr_o <= seed[3] ? {12'h800, seed[15:8]} : {12'h000, off};
      br_addr_o <= seed[4] ? {12'h801, seed[23:16]} : {12'h000, boff};
      if (seed[0] && !seed[3] && both) begin
        m_exec[off] = 1'b1;
      end
      if (seed[1] && !seed[4]) begin
        if (seed[2]) begin
          m_true[boff] = 1'b1;
        end else begin
          m_false[boff] = 1'b1;
        end
      end
    end
    // idle: addresses no longer hold their last value
    @(posedge clk_i);
    fetch_valid_o <= 1'b0;
    br_valid_o <= 1'b0;
    fetch_addr_o <= ~fetch_addr_o;
    br_addr_o <= ~br_addr_o;
  endtask : run
endmodule : ccm_core_model

// ### tb_code_coverage_memory_map.sv
// self-checking bench for the coverage capture core
module tb_code_coverage_memory_map;
  timeunit 1ns;
  timeprecision 1ps;
  import ccm_pkg::*;
  localparam int SWEEP = 255; // shortened sweep, indices 0..255 only
  logic clk_i, resetn_i, halted_i, mode_both_i, clear_i, cfg_we_i, cfg_kind_i, cfg_en_i, rd_en_i;
  logic [BLK_W-1:0] cfg_blk_i; // block number
  logic [ADDR_W-1:0] cfg_base_i, rd_addr_i; // base and readout address
  logic fv, bv, bt; // core event strobes
  logic [ADDR_W-1:0] fa, ba; // core event addresses
  logic busy_o, rd_valid_o, rd_exec_o, rd_true_o, rd_false_o, rd_mapped_o;
  int err_count; // mismatches
  int checks_done; // comparisons
  logic [7:0] exp_q[$]; // notes: {mask, mapped exec true false}
  logic [7:0] note; // oldest note
  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ccm_core_model u_core (.clk_i(clk_i), .fetch_valid_o(fv), .fetch_addr_o(fa), .br_valid_o(bv),
    .br_addr_o(ba), .br_taken_o(bt));
  ccm_top #(.SWEEP_LAST(SWEEP_W'(SWEEP))) dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .halted_i(halted_i), .mode_both_i(mode_both_i), .fetch_valid_i(fv), .fetch_addr_i(fa),
    .br_valid_i(bv), .br_addr_i(ba), .br_taken_i(bt), .clear_i(clear_i), .cfg_we_i(cfg_we_i),
    .cfg_kind_i(cfg_kind_i), .cfg_blk_i(cfg_blk_i), .cfg_en_i(cfg_en_i), .cfg_base_i(cfg_base_i),
    .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .busy_o(busy_o), .rd_valid_o(rd_valid_o),
    .rd_exec_o(rd_exec_o), .rd_true_o(rd_true_o), .rd_false_o(rd_false_o),
    .rd_mapped_o(rd_mapped_o));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // take the oldest note whenever a readout answer appears
  always @(posedge clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        note = exp_q.pop_front();
        check({28'h0, {rd_mapped_o, rd_exec_o, rd_true_o, rd_false_o} & note[7:4]},
          {28'h0, note[3:0] & note[7:4]});
      end
    end
  end
  // one read request; noted only when the target is halted
  task automatic rd(input logic [19:0] a, input logic [3:0] mask, input logic [3:0] want);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    rd_addr_i <= a;
    if (halted_i === 1'b1) begin
      exp_q.push_back({mask, want});
    end
  endtask : rd
  // end a read burst and let every answer land
  task automatic rd_end();
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    rd_addr_i <= ~rd_addr_i;
    repeat (3) @(posedge clk_i);
    check(32'(exp_q.size()), 32'h0);
  endtask : rd_end
  // back-to-back reads of a range against the core model
  task automatic rd_range(input int lo, input int n);
    for (int i = lo; i < lo + n; i++) begin
      rd(20'(i), 4'hf, {1'b1, u_core.m_exec[i], u_core.m_true[i], u_core.m_false[i]});
    end
    rd_end();
  endtask : rd_range
  // wait out a sweep; a remap or clear sweep has a fixed length
  task automatic sweep(input bit exact);
    int cnt;
    cnt = 0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk_i);
      if (busy_o === 1'b1) begin
        cnt++;
      end else if (cnt > 0 || !exact) begin
        break;
      end
    end
    if (exact) begin
      check(32'(cnt), 32'(SWEEP + 1));
    end
  endtask : sweep
  // host map write pulse
  task automatic map(input logic kind, input logic [2:0] blk, input logic en, input logic [19:0] b);
    @(posedge clk_i);
    cfg_we_i <= 1'b1;
    cfg_kind_i <= kind;
    cfg_blk_i <= blk;
    cfg_en_i <= en;
    cfg_base_i <= b;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
    if (halted_i === 1'b1) begin
      sweep(1'b1);
    end
  endtask : map
  // let the core run, then halt it
  task automatic run(input int n, input logic [7:0] lo, input logic both);
    @(posedge clk_i);
    halted_i <= 1'b0;
    mode_both_i <= both;
    u_core.run(n, lo, both);
    @(posedge clk_i);
    halted_i <= 1'b1;
  endtask : run
  // watchdog
  initial begin
    #200000;
    err_count++;
    results();
  end
  // main sequence
  initial begin
    {resetn_i, clear_i, cfg_we_i, cfg_kind_i, cfg_en_i, rd_en_i} = '0;
    {halted_i, mode_both_i} = 2'b11;
    cfg_blk_i = '0;
    cfg_base_i = '0;
    rd_addr_i = '0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    sweep(1'b0);
    // default map: rom blocks high, ram blocks at zero
    rd(20'hc0005, 4'h8, 4'h8);
    rd(20'he0005, 4'h8, 4'h8);
    rd(20'h00005, 4'h8, 4'h8);
    rd(20'h60000, 4'h8, 4'h0);
    rd_end();
    // block 0 of both maps to zero with low bits ignored; block 1 off
    map(KIND_STMT, 3'h0, 1'b1, 20'h3ffff);
    map(KIND_STMT, 3'h1, 1'b0, 20'h40000);
    map(KIND_BR, 3'h0, 1'b1, 20'h1ffff);
    map(KIND_BR, 3'h1, 1'b0, 20'h20000);
    rd(20'h3ffff, 4'h8, 4'h8);
    rd(20'h40000, 4'h8, 4'h0);
    rd(20'h20000, 4'h8, 4'h8);
    rd_end();
    // while running, host writes and reads are ignored
    @(posedge clk_i);
    halted_i <= 1'b0;
    map(KIND_STMT, 3'h0, 1'b1, 20'h40000);
    repeat (2) @(posedge clk_i);
    check({31'h0, busy_o}, 32'h0);
    rd(20'h00001, 4'hf, 4'h0);
    rd_end();
    run(400, 8'h00, 1'b1);
    rd_range(0, 64);
    // branch-only mode: statements not recorded, branch block 0 reaches only 128 kbyte
    run(400, 8'h80, 1'b0);
    rd(20'h20000, 4'h8, 4'h0);
    rd(20'h1ffff, 4'h8, 4'h8);
    rd_range(128, 64);
    // results accumulate over runs
    run(200, 8'h00, 1'b1);
    rd_range(0, 64);
    // remap keeps earlier results readable
    map(KIND_STMT, 3'h0, 1'b1, 20'h40000);
    rd_range(0, 192);
    // a scattered, non-adjacent block
    map(KIND_STMT, 3'h2, 1'b1, 20'hc0000);
    rd(20'hc0010, 4'h8, 4'h8);
    rd(20'h80000, 4'h8, 4'h0);
    rd_end();
    // clear wipes live data and retention
    @(posedge clk_i);
    clear_i <= 1'b1;
    @(posedge clk_i);
    clear_i <= 1'b0;
    sweep(1'b1);
    u_core.m_exec = '0;
    u_core.m_true = '0;
    u_core.m_false = '0;
    rd_range(0, 256);
    results();
  end
endmodule : tb_code_coverage_memory_map
